// ==== core/eeprom_array_store.sv ====
// eeprom_array_store: the byte array behind the command logic
// assumes commits arrive on clk and reads never overlap a commit
`timescale 1ns/1ps

module eeprom_array_store #(
  parameter int AW = eeprom_cmd_pkg::ARRAY_ADDR_BITS
) (
  // system clock
  input wire logic clk,
  // commit and read port
  array_port_if.store io
);
  import eeprom_cmd_pkg::*;

  logic [7:0] cells [2**AW];

  // one byte committed per clock while latch_set_cmd is high
  always_ff @(posedge clk)
  begin
    if (io.latch_set_cmd)
      cells[io.wrAddr] <= io.wrData;
  end

  // read is asynchronous; the link side only reads while no commit runs
  assign io.rdData = cells[io.rdAddr];
endmodule : eeprom_array_store

// ==== core/spi_eeprom_command_protect.sv ====
// spi_eeprom_command_protect: spi slave command decode, write latch, status, protection
// assumes an spi master in mode 0 or 3 drives sck, csN, si, holdN; wpN is a board pin
`timescale 1ns/1ps

module spi_eeprom_command_protect #(
  parameter int ARRAY_AW = eeprom_cmd_pkg::ARRAY_ADDR_BITS,
  parameter int WRITE_CYCLES = eeprom_cmd_pkg::WRITE_CYCLE_CNT
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // spi link from the master
  input wire logic sck,
  input wire logic csN,
  input wire logic si,
  input wire logic holdN,
  // hardware protect pin
  input wire logic wpN,
  // serial output with its enable
  output logic so,
  output logic soOe
);
  import eeprom_cmd_pkg::*;

  localparam int CW = $clog2(WRITE_CYCLES + 1);
  localparam int BW = ARRAY_AW - PAGE_BITS;

  // ---------------------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------------------
  // link side, clocked by sck
  typedef struct packed {
    logic [7:0] statMeta;
    logic [7:0] statSeen;
    phase_t phase;
    logic [2:0] bitCnt;
    logic [7:0] rxShift;
    logic [7:0] txShift;
    cmd_t cmd;
    logic done;
    logic resultTgl;
    logic [ADDR_BITS-1:0] addr;
    logic [7:0] statusNew;
    logic [PAGE_BYTES-1:0] mask;
  } link_t;

  // control side, clocked by clk
  typedef struct packed {
    logic csMeta;
    logic csSeen;
    logic csPrev;
    logic wpMeta;
    logic wpSeen;
    logic wpPrev;
    logic tglMeta;
    logic tglSeen;
    logic tglRef;
    logic wpFell;
    logic latch;
    logic [1:0] level;
    logic pinEn;
    logic busy;
    logic [CW-1:0] cnt;
    cmd_t pend;
    logic [7:0] pendStat;
    logic [BW-1:0] pageBase;
    logic [PAGE_BYTES-1:0] pendMask;
    logic [7:0] statusWord;
  } ctl_t;

  localparam link_t LINK_RESET = '{phase: PH_DEAD, cmd: CMD_NONE, default: '0};
  localparam ctl_t CTL_RESET = '{csMeta: 1'b1, csSeen: 1'b1, csPrev: 1'b1,
    wpMeta: 1'b1, wpSeen: 1'b1, wpPrev: 1'b1, latch: LATCH_RESET,
    level: LEVEL_RESET, pinEn: PIN_EN_RESET, pend: CMD_NONE, default: '0};

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  link_t ls;
  link_t nl;
  link_t cur;
  ctl_t cs;
  ctl_t nc;
  logic frameLive;
  logic frameRstN;
  logic outRstN;
  logic soOeRaw;
  logic [7:0] pageBuf [PAGE_BYTES];
  logic bufWe;
  logic [PAGE_BITS-1:0] bufIdx;
  logic [7:0] bufData;
  logic [7:0] rx;
  logic lastBit;
  cmd_t opc;
  logic csRise;
  logic csFall;
  logic wpFall;
  logic hwLock;
  logic fresh;
  logic [PAGE_BITS-1:0] commitIdx;
  logic [ARRAY_AW-1:0] commitAddr;
  logic [7:0] stWord;

  array_port_if #(.AW(ARRAY_AW)) arr ();

  eeprom_array_store #(.AW(ARRAY_AW)) u_store (
    .clk(clk),
    .io(arr.store)
  );

  // ---------------------------------------------------------------------------
  // link domain: frame tracking
  // ---------------------------------------------------------------------------
  // sck is only ever an input; nothing here drives it
  assign frameRstN = rst_n & ~csN;

  // first rising edge of a selected frame restarts the sequencer
  always_ff @(posedge sck or negedge frameRstN)
  begin
    if (!frameRstN)
      frameLive <= 1'b0;
    else if (holdN)
      frameLive <= 1'b1;
  end

  // ---------------------------------------------------------------------------
  // link domain: shift engine and opcode decode
  // ---------------------------------------------------------------------------
  // results stay put after csN rises so the clk side can pick them up;
  // they are rewritten only at the next opcode, eight edges into a frame
  always_comb
  begin
    cur = ls;
    nl = ls;
    rx = '0;
    lastBit = 1'b0;
    opc = CMD_NONE;
    bufWe = 1'b0;
    bufIdx = '0;
    bufData = '0;
    // status word crosses on every link edge, two flops
    nl.statMeta = cs.statusWord;
    nl.statSeen = ls.statMeta;
    if (!csN && holdN)
    begin
      if (!frameLive)
      begin
        cur.phase = PH_OPCODE;
        cur.bitCnt = '0;
      end
      rx = {cur.rxShift[6:0], si};
      lastBit = (cur.bitCnt == 3'h7);
      nl.phase = cur.phase;
      nl.bitCnt = cur.bitCnt + 3'h1;
      nl.rxShift = rx;
      nl.txShift = {ls.txShift[6:0], 1'b0};
      case (cur.phase)
        PH_OPCODE:
        begin
          if (lastBit)
          begin
            opc = decode_op(rx);
            // only status read is honoured during a write cycle
            if (ls.statSeen[ST_BUSY] && opc != CMD_STAT_RD)
              opc = CMD_BAD;
            nl.cmd = opc;
            nl.done = 1'b0;
            nl.mask = '0;
            case (opc)
              CMD_LATCH_SET, CMD_LATCH_CLR:
              begin
                nl.done = 1'b1;
                nl.resultTgl = ~ls.resultTgl;
                nl.phase = PH_DEAD;
              end
              CMD_STAT_WR:
              begin
                nl.resultTgl = ~ls.resultTgl;
                nl.phase = PH_RX_DATA;
              end
              CMD_ARR_WR:
              begin
                nl.resultTgl = ~ls.resultTgl;
                nl.phase = PH_ADDR_HI;
              end
              CMD_ARR_RD:
                nl.phase = PH_ADDR_HI;
              CMD_STAT_RD:
              begin
                nl.phase = PH_TX_DATA;
                nl.txShift = ls.statSeen;
              end
              default:
                nl.phase = PH_DEAD;
            endcase
          end
        end
        PH_ADDR_HI:
        begin
          if (lastBit)
          begin
            nl.addr[15:8] = rx;
            nl.phase = PH_ADDR_LO;
          end
        end
        PH_ADDR_LO:
        begin
          if (lastBit)
          begin
            nl.addr[7:0] = rx;
            if (ls.cmd == CMD_ARR_RD)
            begin
              nl.phase = PH_TX_DATA;
              nl.txShift = arr.rdData;
            end
            else
              nl.phase = PH_RX_DATA;
          end
        end
        PH_RX_DATA:
        begin
          // a partial byte leaves the frame unfinished
          nl.done = lastBit;
          if (lastBit && ls.cmd == CMD_STAT_WR)
          begin
            nl.statusNew = rx;
            nl.phase = PH_DEAD;
          end
          else if (lastBit)
          begin
            bufWe = 1'b1;
            bufIdx = ls.addr[PAGE_BITS-1:0];
            bufData = rx;
            nl.mask[ls.addr[PAGE_BITS-1:0]] = 1'b1;
            // only the page offset moves; later bytes overwrite earlier ones
            nl.addr[PAGE_BITS-1:0] = ls.addr[PAGE_BITS-1:0] + 5'h01;
          end
        end
        PH_TX_DATA:
        begin
          if (lastBit && ls.cmd == CMD_ARR_RD)
          begin
            // 16 bit pointer; array index uses low bits so the top wraps to 0
            nl.addr = ls.addr + 16'h0001;
            nl.txShift = arr.rdData;
          end
          else if (lastBit)
            nl.txShift = ls.statSeen;
        end
        default:
        begin
          // clocks beyond the status byte void the status write
          if (ls.cmd == CMD_STAT_WR)
            nl.done = 1'b0;
        end
      endcase
    end
  end

  // read pointer follows the next address so data is ready on load
  assign arr.rdAddr = nl.addr[ARRAY_AW-1:0];

  // link state register
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
      ls <= LINK_RESET;
    else
      ls <= nl;
  end

  // page buffer, read by the clk side only after the frame ended
  always_ff @(posedge sck)
  begin
    if (bufWe)
      pageBuf[bufIdx] <= bufData;
  end

  // ---------------------------------------------------------------------------
  // link domain: serial output
  // ---------------------------------------------------------------------------
  assign outRstN = rst_n & ~csN;

  // output changes on the falling edge, the master samples on the rising one
  always_ff @(negedge sck or negedge outRstN)
  begin
    if (!outRstN)
    begin
      so <= 1'b0;
      soOeRaw <= 1'b0;
    end
    else
    begin
      so <= ls.txShift[7];
      soOeRaw <= frameLive && (ls.phase == PH_TX_DATA);
    end
  end

  // pause must float the pin at once, not at the next falling edge
  assign soOe = soOeRaw & holdN;

  // ---------------------------------------------------------------------------
  // clk domain: synchronisers, write latch, status and write cycle
  // ---------------------------------------------------------------------------
  always_comb
  begin
    nc = cs;
    stWord = '0;
    nc.csMeta = csN;
    nc.csSeen = cs.csMeta;
    nc.csPrev = cs.csSeen;
    nc.wpMeta = wpN;
    nc.wpSeen = cs.wpMeta;
    nc.wpPrev = cs.wpSeen;
    nc.tglMeta = ls.resultTgl;
    nc.tglSeen = cs.tglMeta;
    csRise = cs.csSeen & ~cs.csPrev;
    csFall = ~cs.csSeen & cs.csPrev;
    wpFall = ~cs.wpSeen & cs.wpPrev;
    hwLock = cs.pinEn & ~cs.wpSeen;
    // act only on a frame whose opcode arrived after csN fell
    fresh = csRise && (cs.tglSeen != cs.tglRef) && ls.done;
    if (csFall)
    begin
      nc.tglRef = cs.tglSeen;
      nc.wpFell = 1'b0;
    end
    // a fall in the same cycle as the clear still counts
    if (!cs.csSeen && wpFall)
      nc.wpFell = 1'b1;
    if (cs.busy)
    begin
      nc.cnt = cs.cnt + CW'(1);
      if (cs.cnt == CW'(WRITE_CYCLES - 1))
      begin
        nc.busy = 1'b0;
        nc.latch = 1'b0;
        nc.pend = CMD_NONE;
        if (cs.pend == CMD_STAT_WR)
        begin
          nc.level = cs.pendStat[ST_LVL_HI:ST_LVL_LO];
          nc.pinEn = cs.pendStat[ST_PIN_EN];
        end
      end
    end
    else if (fresh)
    begin
      case (ls.cmd)
        CMD_LATCH_SET:
          nc.latch = 1'b1;
        CMD_LATCH_CLR:
          nc.latch = 1'b0;
        CMD_STAT_WR:
        begin
          // pin fall during the frame only matters when the pin is enabled
          if (cs.latch && !hwLock && !(cs.pinEn && cs.wpFell))
          begin
            nc.busy = 1'b1;
            nc.cnt = '0;
            nc.pend = CMD_STAT_WR;
            nc.pendStat = ls.statusNew;
          end
        end
        CMD_ARR_WR:
        begin
          if (cs.latch)
          begin
            nc.busy = 1'b1;
            nc.cnt = '0;
            nc.pend = CMD_ARR_WR;
            nc.pageBase = ls.addr[ARRAY_AW-1:PAGE_BITS];
            nc.pendMask = ls.mask;
          end
        end
        default:
          nc.pend = cs.pend;
      endcase
    end
    // status byte as the link side will shift it out
    if (nc.busy)
      stWord = ST_BUSY_WORD;
    else
    begin
      stWord[ST_LATCH] = nc.latch;
      stWord[ST_LVL_HI:ST_LVL_LO] = nc.level;
      stWord[ST_PIN_EN] = nc.pinEn;
    end
    nc.statusWord = stWord;
  end

  // control state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cs <= CTL_RESET;
    else
      cs <= nc;
  end

  // ---------------------------------------------------------------------------
  // clk domain: page commit into the array
  // ---------------------------------------------------------------------------
  // one byte per clock in the first page-size counts of the cycle; needs
  // WRITE_CYCLES of at least one page
  assign commitIdx = cs.cnt[PAGE_BITS-1:0];
  assign commitAddr = {cs.pageBase, commitIdx};
  assign arr.wrAddr = commitAddr;
  assign arr.wrData = pageBuf[commitIdx];
  assign arr.latch_set_cmd = cs.busy && (cs.pend == CMD_ARR_WR) && (cs.cnt < CW'(PAGE_BYTES)) &&
    cs.pendMask[commitIdx] &&
    !block_hit(cs.level, commitAddr[ARRAY_AW-1 -: 2]);
endmodule : spi_eeprom_command_protect

// ==== dv/spi_eeprom_command_protect_properties.sv ====
// checker: pin relations of the eeprom command block
// assumes spi mode 0 or 3 frames; bound onto the command block
`timescale 1ns/1ps

module spi_eeprom_command_protect_properties (
  // clocks and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  // link and board pins
  input wire logic csN,
  input wire logic si,
  input wire logic holdN,
  input wire logic wpN,
  input wire logic so,
  input wire logic soOe
);
  import eeprom_cmd_pkg::*;
  // ----------------------------------------
  // frame shadow, cleared by deselect
  // ----------------------------------------
  logic [5:0] bitCnt_ff;
  logic [7:0] op_ff;
  logic [7:0] cap_ff;
  logic [7:0] prev_ff;
  logic got_ff;
  logic havePrev_ff;
  logic isRd;
  logic isOut;
  // only the two read opcodes may ever drive so
  assign isRd = (op_ff & OP_MASK) == OP_STAT_RD;
  assign isOut = isRd || ((op_ff & OP_MASK) == OP_ARR_RD);
  // paused edges are skipped, as the slave must skip them too
  always_ff @(posedge sck or posedge csN or negedge rst_n)
  begin
    if (!rst_n || csN)
    begin
      bitCnt_ff <= 6'h00;
      op_ff <= 8'h00;
      cap_ff <= 8'h00;
      prev_ff <= 8'h00;
      got_ff <= 1'b0;
      havePrev_ff <= 1'b0;
    end
    else if (holdN)
    begin
      bitCnt_ff <= bitCnt_ff + {5'h00, bitCnt_ff != 6'h3F};
      op_ff <= (bitCnt_ff < 6'h08) ? {op_ff[6:0], si} : op_ff;
      cap_ff <= {cap_ff[6:0], so};
      got_ff <= isRd && (bitCnt_ff >= 6'h0F) && (bitCnt_ff[2:0] == 3'h7);
      prev_ff <= got_ff ? cap_ff : prev_ff;
      havePrev_ff <= havePrev_ff || got_ff;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_desel_mute: assert property (@(posedge clk) disable iff (!rst_n) csN |-> !soOe)
    else $error("so driven while deselected");
  a_pause_mute: assert property (@(posedge clk) disable iff (!rst_n) !holdN |-> !soOe)
    else $error("so driven while paused");
  a_opcode_first: assert property (@(posedge clk) disable iff (!rst_n)
    bitCnt_ff < 6'h08 |-> !soOe)
    else $error("so driven before opcode complete");
  a_quiet_cmds: assert property (@(posedge clk) disable iff (!rst_n)
    (bitCnt_ff >= 6'h08) && !isOut |-> !soOe)
    else $error("so driven after non read opcode");
  a_stat_drives: assert property (@(posedge sck) disable iff (!rst_n)
    !csN && isRd && (bitCnt_ff == 6'h08) && holdN && $past(holdN) |-> soOe)
    else $error("status not driven after opcode");
  a_busy_word: assert property (@(posedge sck) disable iff (!rst_n)
    !csN && got_ff && cap_ff[0] |-> cap_ff == ST_BUSY_WORD)
    else $error("busy status not all ones");
  a_stat_pad: assert property (@(posedge sck) disable iff (!rst_n)
    !csN && got_ff && !cap_ff[0] |-> cap_ff[6:4] == 3'h0)
    else $error("status pad bits not zero");
  a_stat_steady: assert property (@(posedge sck) disable iff (!rst_n)
    !csN && got_ff && havePrev_ff && !cap_ff[0] && !prev_ff[0] |-> cap_ff == prev_ff)
    else $error("ready status changed inside frame");
  c_busy_seen: cover property (@(posedge sck) got_ff && cap_ff[0]);
  c_ready_seen: cover property (@(posedge sck) got_ff && !cap_ff[0]);
  c_pause_seen: cover property (@(posedge clk) !csN && !holdN);
  c_pin_fall: cover property (@(posedge clk) !csN && $fell(wpN));
endmodule : spi_eeprom_command_protect_properties

bind spi_eeprom_command_protect spi_eeprom_command_protect_properties u_props (
  .clk(clk), .rst_n(rst_n), .sck(sck), .csN(csN), .si(si), .holdN(holdN),
  .wpN(wpN), .so(so), .soOe(soOe));

// ==== dv/spi_eeprom_command_protect_tb.sv ====
// spi_eeprom_command_protect_tb: command, status and protection sequences
// assumes the master model frames every access; short write cycle
`timescale 1ns/1ps

module spi_eeprom_command_protect_tb;
  import eeprom_cmd_pkg::*;
  localparam int WCYC = 64;
  localparam int LIMIT = 60000;
  logic clk;
  logic rst_n;
  logic wpN;
  logic sck;
  logic csN;
  logic si;
  logic holdN;
  logic so;
  logic soOe;
  logic [7:0] rx[$];
  logic [7:0] v;
  logic [7:0] ops [4] = '{8'h0E, 8'h0C, 8'h06, 8'h04};
  logic [7:0] opExp [4] = '{8'h02, 8'h00, 8'h02, 8'h00};
  logic [7:0] bad [3] = '{8'h15, 8'h07, 8'h00};
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  // clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  spi_eeprom_command_protect #(.ARRAY_AW(13), .WRITE_CYCLES(WCYC)) u_spi_eeprom_command_protect (
    .clk(clk), .rst_n(rst_n), .sck(sck), .csN(csN), .si(si), .holdN(holdN),
    .wpN(wpN), .so(so), .soOe(soOe));
  spi_master_model u_spi_master_model (
    .sck(sck), .csN(csN), .si(si), .holdN(holdN), .so(so), .soOe(soOe));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic send(input logic [7:0] tx[$]);
    u_spi_master_model.xfer(tx, rx, -1);
  endtask : send
  task automatic stat(input logic [7:0] exp, input logic [7:0] m = 8'hFF);
    // a fourth byte lets the checker see two whole status bytes in one frame
    send('{OP_STAT_RD, 8'h00, 8'h00, 8'h00});
    check(rx[1] & m, exp);
  endtask : stat
  task automatic wrStat(input logic [7:0] val);
    send('{OP_LATCH_SET});
    send('{OP_STAT_WR, val});
  endtask : wrStat
  // bounded poll of the busy flag
  task automatic idle();
    for (int i = 0; i < 40; i++)
    begin
      send('{OP_STAT_RD, 8'h00, 8'h00, 8'h00});
      if (rx[1][0] === 1'b0) break;
    end
  endtask : idle
  task automatic wrArr(input logic [15:0] a, input logic [7:0] d[$]);
    send('{OP_LATCH_SET});
    send({OP_ARR_WR, a[15:8], a[7:0], d});
    idle();
  endtask : wrArr
  task automatic rdArr(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    send('{OP_ARR_RD, a[15:8], a[7:0], 8'h00, 8'h00});
    check(rx[3], e0);
    check(rx[4], e1);
  endtask : rdArr
  task automatic fin(input string name);
    $display("test %s finished", name);
  endtask : fin
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_mismatch++;
      $display("Error at %0t: run too long", $time);
      test_done();
    end
  end
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    wpN = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    stat(8'h00);
    fin("reset");
    @(posedge clk) wpN <= 1'b0;
    foreach (ops[i])
    begin
      send('{ops[i]});
      stat(opExp[i]);
    end
    send('{OP_STAT_WR, 8'h8C});
    stat(8'h00);
    fin("latch");
    for (int l = 0; l < 4; l++)
    begin
      v = {4'h0, l[1:0], 2'h0};
      wrStat(v);
      stat(8'hFF);
      idle();
      stat(v);
    end
    fin("levels");
    wrStat(8'h8C);
    idle();
    stat(8'h8C);
    wrStat(8'h00);
    idle();
    stat(8'h8C, 8'hFD);
    @(posedge clk) wpN <= 1'b1;
    send('{OP_LATCH_SET});
    fork
      send('{OP_STAT_WR, 8'h00});
      begin
        // send drops csN in this same step; waiting for its edge would miss it
        repeat (4) @(posedge clk);
        wpN <= 1'b0;
        // pin back high before csN rises, so only the in-frame fall can abort
        repeat (10) @(posedge clk);
        wpN <= 1'b1;
      end
    join
    idle();
    stat(8'h8C, 8'hFD);
    @(posedge clk) wpN <= 1'b1;
    wrStat(8'h00);
    @(posedge clk) wpN <= 1'b0;
    idle();
    stat(8'h00);
    fin("protect pin");
    wrArr(16'h1FFF, '{8'h5A, 8'hA5, 8'hC3});
    wrArr(16'h001F, '{8'h11, 8'h22});
    rdArr(16'h1FFF, 8'h5A, 8'h22);
    rdArr(16'h1FE0, 8'hA5, 8'hC3);
    send('{OP_ARR_WR, 8'h00, 8'h00, 8'h77});
    rdArr(16'h1FFF, 8'h5A, 8'h22);
    wrStat(8'h84);
    idle();
    stat(8'h84);
    wrArr(16'h1FFF, '{8'h00});
    wrArr(16'h0000, '{8'h33});
    rdArr(16'h1FFF, 8'h5A, 8'h33);
    fin("array");
    foreach (bad[i]) send('{bad[i], 8'h00, 8'h00});
    stat(8'h84);
    u_spi_master_model.xfer('{OP_STAT_RD, 8'h00, 8'h00}, rx, 3);
    check(rx[1], 8'h84);
    // pause in the middle of the status byte, while so is driven
    u_spi_master_model.xfer('{OP_STAT_RD, 8'h00, 8'h00}, rx, 11);
    check(rx[1], 8'h84);
    fin("opcode and pause");
    test_done();
  end
endmodule : spi_eeprom_command_protect_tb

// ==== dv/spi_master_model.sv ====
// spi_master_model: mode 0 master that frames bytes toward the eeprom
// spaces frames itself, idling 600 ns after csN rises; sck stands still between frames
`timescale 1ns/1ps

module spi_master_model (
  // link pins toward the slave
  output logic sck,
  output logic csN,
  output logic si,
  output logic holdN,
  // slave output and its enable
  input wire logic so,
  input wire logic soOe
);
  localparam int HALF_NS = 80;
  logic lastSo;
  // sck is only ever made here
  initial
  begin
    sck = 1'b0;
    csN = 1'b1;
    si = 1'b0;
    holdN = 1'b1;
    lastSo = 1'b0;
  end
  // a floating so reads as the inverse of its last level, never a lucky match
  always @(so or soOe) if (soOe) lastSo = so;
  // ----------------------------------------
  // one frame, msb first, optional pause before bit pauseAt
  // ----------------------------------------
  task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx[$], input int pauseAt);
    logic [7:0] b;
    rx = {};
    csN = 1'b0;
    #HALF_NS;
    for (int i = 0; i < tx.size(); i++)
    begin
      for (int k = 7; k >= 0; k--)
      begin
        si = tx[i][k];
        if ((8 * i + 7 - k) == pauseAt)
        begin
          holdN = 1'b0; // moved with sck low
          si = ~si;
          #HALF_NS sck = 1'b1;
          #HALF_NS sck = 1'b0;
          si = tx[i][k];
          holdN = 1'b1;
        end
        #HALF_NS sck = 1'b1;
        b[k] = soOe ? so : ~lastSo;
        #HALF_NS sck = 1'b0;
      end
      rx.push_back(b);
    end
    #(HALF_NS / 2) csN = 1'b1; // inside the low time after the last bit
    si = ~si;
    #600;
  endtask : xfer
endmodule : spi_master_model

// ==== pkg/array_port_if.sv ====
// array_port_if: commit and read port between command logic and array store
// assumes writes come from the system clock, reads from the link clock
`timescale 1ns/1ps

interface array_port_if #(
  parameter int AW = eeprom_cmd_pkg::ARRAY_ADDR_BITS
);
  logic latch_set_cmd;
  logic [AW-1:0] wrAddr;
  logic [7:0] wrData;
  logic [AW-1:0] rdAddr;
  logic [7:0] rdData;
  // command logic side
  modport user (output latch_set_cmd, output wrAddr, output wrData, output rdAddr, input rdData);
  // array side
  modport store (input latch_set_cmd, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : array_port_if

// ==== pkg/eeprom_cmd_pkg.sv ====
// eeprom_cmd_pkg: opcodes, status layout, timing and shared types of the eeprom
// assumes a 10 MHz system clock and an spi master driving the link pins
//
// Behaviour
// - slave only, serial clock always an input
// - all bytes shifted most significant bit first
// - chip select fall starts frame, first byte opcode
// - bad opcode: ignore input, output floats until reselect
// - deselected: ignore input, output floats
// - pause floats output, freezes sequence, resumes intact
// - pin low plus enable bit refuses status writes
// - pin fall inside status write frame aborts it
// - enable bit clear makes pin ignored
// - opcodes for latch set and latch clear
// - opcodes for array read and array write
// - status read opcode shifts out status byte
// - write latch cleared at power up
// - latch clear works regardless of pin
// - bit 0 busy during write cycle
// - bit 1 latch; 3:2 level; 7 enable
// - bits 6:4 zero; all ones while busy
// - status write sets block protect level
// - protect bits need latch and timed cycle
// - protected segments refuse array writes, others accept
// - enable bit cannot clear while pin held low
// - reads stream with address increment and wrap
// - page writes wrap within 32 byte page
// - programming starts only at chip select rise
// - write latch cleared when write cycle ends
package eeprom_cmd_pkg;
  // ---------------------------------------------------------------------------
  // opcodes, bit 3 ignored by the decoder
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OP_MASK = 8'hF7;
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_ARR_RD = 8'h03;
  localparam logic [7:0] OP_ARR_WR = 8'h02;
  // ---------------------------------------------------------------------------
  // status layout and reset values
  // ---------------------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_LVL_LO = 2;
  localparam int ST_LVL_HI = 3;
  localparam int ST_PIN_EN = 7;
  localparam logic [7:0] ST_BUSY_WORD = 8'hFF;
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_QUARTER = 2'h1;
  localparam logic [1:0] LVL_HALF = 2'h2;
  localparam logic [1:0] LVL_ALL = 2'h3;
  localparam logic [1:0] LEVEL_RESET = 2'h0;
  localparam logic PIN_EN_RESET = 1'b0;
  localparam logic LATCH_RESET = 1'b0;
  // ---------------------------------------------------------------------------
  // sizes and timing
  // ---------------------------------------------------------------------------
  localparam int ADDR_BITS = 16;
  localparam int ARRAY_ADDR_BITS = 13;
  localparam int PAGE_BITS = 5;
  localparam int PAGE_BYTES = 32;
  localparam int CLK_PERIOD_NS = 100;
  localparam int WRITE_CYCLE_NS = 5000000;
  localparam int WRITE_CYCLE_CNT = WRITE_CYCLE_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_LATCH_SET, CMD_LATCH_CLR, CMD_STAT_RD,
    CMD_STAT_WR, CMD_ARR_RD, CMD_ARR_WR, CMD_BAD
  } cmd_t;

  typedef enum logic [2:0] {
    PH_OPCODE, PH_ADDR_HI, PH_ADDR_LO, PH_RX_DATA, PH_TX_DATA, PH_DEAD
  } phase_t;

  // opcode byte to command, anything unlisted is bad
  function automatic cmd_t decode_op(input logic [7:0] op);
    logic [7:0] key;
    key = op & OP_MASK;
    if (key == OP_LATCH_SET) return CMD_LATCH_SET;
    else if (key == OP_LATCH_CLR) return CMD_LATCH_CLR;
    else if (key == OP_STAT_RD) return CMD_STAT_RD;
    else if (key == OP_STAT_WR) return CMD_STAT_WR;
    else if (key == OP_ARR_RD) return CMD_ARR_RD;
    else if (key == OP_ARR_WR) return CMD_ARR_WR;
    return CMD_BAD;
  endfunction : decode_op

  // true when the two top address bits fall in a protected segment
  function automatic logic block_hit(input logic [1:0] level, input logic [1:0] top);
    return (level == LVL_ALL) || (level == LVL_HALF && top[1]) ||
      (level == LVL_QUARTER && top == 2'h3);
  endfunction : block_hit
endpackage : eeprom_cmd_pkg
